// file: verification/scl_fixture.sv
/*
  Programming fixture model: entry, mode clocks, shift frames, store train.
  Assumes the bench calls its tasks; times are scaled to short bench counts.
*/
`timescale 1ns/1ps
module scl_fixture (
  input wire logic clk_sys,
  input wire logic serial_readout_pin,
  output logic shift_clk,
  output logic mode_data_pin,
  output logic mode_boost_level,
  output logic program_entry_pin,
  output logic store_pin
);
  // All pins low at power-up
  initial begin
    shift_clk = 1'b0;
    mode_data_pin = 1'b0;
    mode_boost_level = 1'b0;
    program_entry_pin = 1'b0;
    store_pin = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Drop entry first so every bit is entered again, then hold it high
  task automatic enter();
    program_entry_pin = 1'b0;
    tick(8);
    program_entry_pin = 1'b1;
    tick(6);
  endtask : enter

  // Mode clock: pin swings to the boosted rail for w cycles
  task automatic mode_clk(input int w);
    mode_boost_level = 1'b1;
    mode_data_pin = 1'b1;
    tick(w);
    mode_boost_level = 1'b0;
    mode_data_pin = 1'b0;
    tick(6);
  endtask : mode_clk

  // MSB first, one 32 ns clock per bit; readout sampled before each edge
  task automatic shift(input logic [63:0] v, input int n, output logic [63:0] rb);
    rb = '0;
    for (int i = n - 1; i >= 0; i--) begin
      rb[i] = serial_readout_pin;
      mode_data_pin = v[i];
      #16 shift_clk = 1'b1;
      #16 shift_clk = 1'b0;
      mode_data_pin = ~v[i]; // Hold time over, line no longer valid
      tick(8);
    end
  endtask : shift

  // Store train, shift clock held still meanwhile
  task automatic store(input int n);
    repeat (n) begin
      store_pin = 1'b1;
      tick(10);
      store_pin = 1'b0;
      tick(10);
    end
  endtask : store
endmodule : scl_fixture

// file: verification/scl_loader_chk.sv
/*
  Checker for the loader: commit, readback, mode, field and decode timing.
  Assumes it is bound to scl_loader and sees only that module's ports.
*/
`timescale 1ns/1ps
module scl_loader_chk
  import scl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic serial_readout_pin,
  input wire logic prog_active,
  input wire logic setup_load_mode,
  input wire logic full_load_mode,
  input wire logic [3:0] mode_count,
  input wire logic [3:0] store_count,
  input wire logic store_done,
  input wire logic [6:0] bits_shifted,
  input wire logic eeprom_write,
  input wire logic [57:0] eeprom_data,
  input wire logic [57:0] config_word,
  input wire logic boost_level_select,
  input wire logic [5:0] normal_alarm_limit,
  input wire logic [5:0] drift_baseline,
  input wire logic [11:0] battery_trip_mv,
  input wire logic [2:0] photo_gain_factor
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Commit: one cycle, once per entry, after the tenth pulse in a load mode
  a_commit_word_match: assert property (eeprom_write |-> store_done && eeprom_data == config_word)
    else $error("commit word differs from stored word");
  a_commit_one_cycle: assert property (eeprom_write |=> !eeprom_write)
    else $error("commit strobe longer than one cycle");
  a_commit_after_ten: assert property (eeprom_write |-> store_count == STORE_PULSES && (setup_load_mode || full_load_mode))
    else $error("commit without ten pulses in a load mode");
  a_commit_once: assert property (eeprom_write |-> !$past(store_done))
    else $error("second commit in one entry");
  a_setup_keeps_limits: assert property (eeprom_write && setup_load_mode |-> config_word[35:0] == $past(config_word[35:0]))
    else $error("setup commit changed limit bits");
  a_setup_mode_decode: assert property (setup_load_mode == ($past(prog_active) && $past(mode_count) == MODE_SETUP))
    else $error("setup mode flag wrong");
  // Readout is quiet outside full mode and follows the stored word within it
  a_readout_quiet: assert property (!full_load_mode && !$past(full_load_mode) |-> !serial_readout_pin)
    else $error("readout driven outside full mode");
  a_readout_bit: assert property (full_load_mode && $past(full_load_mode) && $stable(bits_shifted) && $stable(config_word) |-> serial_readout_pin == ((bits_shifted > 7'h39) ? 1'b0 : config_word[7'h39 - bits_shifted]))
    else $error("readout bit wrong");
  a_field_map: assert property (boost_level_select == config_word[BIT_BOOST] && normal_alarm_limit == config_word[35:30] && drift_baseline == config_word[5:0])
    else $error("field outputs differ from stored word");
  // Decoded values lag the word by one cycle; skip two edges after reset
  a_decode_values: assert property ($past(resetn) && $past(resetn, 2) |-> battery_trip_mv == TRIP_BASE_MV + TRIP_STEP_MV * $past(config_word[44:42]) && photo_gain_factor == {1'b0, $past(config_word[37:36])} + 3'h1)
    else $error("decoded value wrong");
  a_entry_drop_clears: assert property ($fell(prog_active) |-> ##[0:4] (mode_count == 4'h0 && !store_done))
    else $error("entry drop left mode or commit state");

  c_setup_commit: cover property (eeprom_write && setup_load_mode);
  c_full_commit: cover property (eeprom_write && full_load_mode);
  c_entry_drop: cover property ($fell(prog_active));
endmodule : scl_loader_chk

bind scl_loader scl_loader_chk u_scl_loader_chk (
  .clk_sys(clk_sys), .resetn(resetn), .serial_readout_pin(serial_readout_pin),
  .prog_active(prog_active), .setup_load_mode(setup_load_mode), .full_load_mode(full_load_mode),
  .mode_count(mode_count), .store_count(store_count), .store_done(store_done),
  .bits_shifted(bits_shifted), .eeprom_write(eeprom_write), .eeprom_data(eeprom_data),
  .config_word(config_word), .boost_level_select(boost_level_select),
  .normal_alarm_limit(normal_alarm_limit), .drift_baseline(drift_baseline),
  .battery_trip_mv(battery_trip_mv), .photo_gain_factor(photo_gain_factor)
);

// file: verification/scl_loader_test.sv
/*
  Testbench for the loader: full and setup loads, readback, refusals.
  Assumes short mode and store counts of 4 cycles; fixture in scl_fixture.
*/
`timescale 1ns/1ps
module scl_loader_test;
  import scl_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn, shift_clk, mode_data_pin, mode_boost_level, program_entry_pin, store_pin;
  logic serial_readout_pin, setup_load_mode, full_load_mode, store_done, eeprom_write;
  logic boost_level_select, horn_pattern_select, smart_link_gas_alarm_enable;
  logic drift_comp_enable, hush_alarm_only;
  logic [3:0] mode_count;
  logic [57:0] eeprom_data, config_word, w, prev;
  logic [5:0] normal_alarm_limit, drift_baseline;
  logic [11:0] battery_trip_mv, emitter_current_ma, integration_time_us;
  logic [2:0] photo_gain_factor;
  logic [63:0] rb;
  wire [40:0] fld;
  int bad_count = 0;
  int n_checks = 0;
  int n_writes = 0;

  scl_loader #(.MODE_MIN_CYC(4), .STORE_MIN_CYC(4)) u_scl_loader (
    .clk_sys(clk_sys), .resetn(resetn), .shift_clk(shift_clk), .mode_data_pin(mode_data_pin),
    .mode_boost_level(mode_boost_level), .program_entry_pin(program_entry_pin),
    .store_pin(store_pin), .serial_readout_pin(serial_readout_pin), .prog_active(),
    .setup_load_mode(setup_load_mode), .full_load_mode(full_load_mode), .mode_count(mode_count),
    .store_count(), .store_done(store_done), .bits_shifted(), .eeprom_write(eeprom_write),
    .eeprom_data(eeprom_data), .config_word(config_word), .factory_bit(fld[40]),
    .boost_level_select(boost_level_select), .alarm_memory_enable(fld[39]),
    .auto_locate_enable(fld[38]), .horn_sync_enable(fld[37]),
    .horn_pattern_select(horn_pattern_select),
    .smart_link_gas_alarm_enable(smart_link_gas_alarm_enable),
    .drift_comp_enable(drift_comp_enable), .hush_without_high_alarm(fld[36]),
    .hush_alarm_only(hush_alarm_only), .smart_hush_cancel(fld[35]), .hush_enable(fld[34]),
    .battery_warning_hush_enable(fld[33]), .battery_trip_point(fld[32:30]),
    .emitter_current_select(fld[29:28]), .integration_time_select(fld[27:26]),
    .photo_gain_select(fld[25:24]), .normal_alarm_limit(normal_alarm_limit),
    .hysteresis_limit(fld[23:18]), .hush_limit(fld[17:12]), .chamber_check_limit(fld[11:6]),
    .alarm_max_limit(fld[5:0]),
    .drift_baseline(drift_baseline), .battery_trip_mv(battery_trip_mv),
    .emitter_current_ma(emitter_current_ma), .integration_time_us(integration_time_us),
    .photo_gain_factor(photo_gain_factor)
  );

  scl_fixture u_scl_fixture (
    .clk_sys(clk_sys), .serial_readout_pin(serial_readout_pin), .shift_clk(shift_clk),
    .mode_data_pin(mode_data_pin), .mode_boost_level(mode_boost_level),
    .program_entry_pin(program_entry_pin), .store_pin(store_pin)
  );

  always #10 clk_sys = ~clk_sys;

  // Count commits as the design reports them
  always @(posedge clk_sys) begin
    if (eeprom_write === 1'b1) n_writes++;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Pass k: factory bit kept 0, codes, alarm max limit and baseline vary with k
  function automatic logic [57:0] make_word(input logic [5:0] k);
    return {1'b0, k[0], 11'h5A5 ^ {11{k[1]}}, k[2:0], k[1:0], ~k[1:0], k[1:0] ^ 2'h2,
            24'hFC0A95, 6'h3F - k, k};
  endfunction : make_word

  // Roughly 8000 cycles expected; two and a half times that cuts a hang
  initial begin
    #400000;
    bad_count++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1'b1;
    u_scl_fixture.tick(3);
    check(config_word, CFG_RESET);
    check({battery_trip_mv, emitter_current_ma, integration_time_us, photo_gain_factor},
          {TRIP_BASE_MV, EMIT_BASE_MA, INTEG_BASE_US, 3'h1});
    // Full loads: short mode pulse ignored, two surplus bits pushed out the top
    prev = CFG_RESET;
    for (int k = 0; k < 8; k++) begin
      w = make_word(6'(k));
      u_scl_fixture.enter();
      u_scl_fixture.mode_clk(2);
      repeat (8) u_scl_fixture.mode_clk(10);
      check({full_load_mode, mode_count}, {1'b1, MODE_FULL});
      u_scl_fixture.shift({4'h0, 2'h3, w}, 60, rb);
      check(rb, {4'h0, prev, 2'h0});
      check(config_word, prev);
      u_scl_fixture.store(10);
      check(config_word, w);
      check(eeprom_data, w);
      check(fld, {w[57], w[55:53], w[49], w[47:36], w[29:6]});
      check(battery_trip_mv, TRIP_BASE_MV + TRIP_STEP_MV * k);
      check(emitter_current_ma, EMIT_BASE_MA + EMIT_STEP_MA * (k % 4));
      check(integration_time_us, INTEG_BASE_US + INTEG_STEP_US * (3 - k % 4));
      check(photo_gain_factor, ((k % 4) ^ 2) + 1);
      u_scl_fixture.store(1);
      check(n_writes, k + 1);
      prev = w;
    end
    // Setup load: upper 22 bits only, readout stays low
    u_scl_fixture.enter();
    repeat (2) u_scl_fixture.mode_clk(10);
    check({setup_load_mode, full_load_mode}, 2'h2);
    u_scl_fixture.shift({42'h0, 22'h199654}, 22, rb);
    check(serial_readout_pin, 1'b0);
    u_scl_fixture.store(10);
    w = {22'h199654, prev[35:0]};
    check(config_word, w);
    check(fld, {w[57], w[55:53], w[49], w[47:36], w[29:6]});
    check({boost_level_select, horn_pattern_select, smart_link_gas_alarm_enable}, 3'h7);
    check({drift_comp_enable, hush_alarm_only}, 2'h1);
    check({battery_trip_mv, emitter_current_ma}, {12'h898, 12'h064});
    check({integration_time_us, photo_gain_factor}, {12'h0C8, 3'h1});
    check({normal_alarm_limit, drift_baseline}, {6'h3F, 6'h07});
    // Re-entry clears state; a store train in mode 1 is refused
    u_scl_fixture.enter();
    check({mode_count, store_done}, 5'h00);
    u_scl_fixture.mode_clk(10);
    u_scl_fixture.shift(64'h0, 10, rb);
    u_scl_fixture.store(10);
    check(n_writes, 9);
    check(config_word, {22'h199654, prev[35:0]});
    final_report();
  end
endmodule : scl_loader_test

// file: verilog/scl_loader.sv
/*
  Serial configuration loader: counts mode clocks after programming entry,
  shifts the configuration word in on the shift clock, commits it on the
  store pulse train, offers serial readback, and presents the stored fields.
  Assumes the fixture drives the data pin set up around the shift clock
  rising edge, and leaves the shift clock still while storing.
  Every output comes from a flip-flop; the mode flags trail the mode count.
*/
`timescale 1ns/1ps

module scl_loader
  import scl_pkg::*;
#(
  parameter int unsigned MODE_MIN_CYC = MODE_MIN_CYC_DEF,
  parameter int unsigned STORE_MIN_CYC = STORE_MIN_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic shift_clk,
  input wire logic mode_data_pin,
  input wire logic mode_boost_level,
  input wire logic program_entry_pin,
  input wire logic store_pin,
  output logic serial_readout_pin,
  output logic prog_active,
  output logic setup_load_mode,
  output logic full_load_mode,
  output logic [3:0] mode_count,
  output logic [3:0] store_count,
  output logic store_done,
  output logic [6:0] bits_shifted,
  output logic eeprom_write,
  output logic [57:0] eeprom_data,
  output logic [57:0] config_word,
  output logic factory_bit,
  output logic boost_level_select,
  output logic alarm_memory_enable,
  output logic auto_locate_enable,
  output logic horn_sync_enable,
  output logic horn_pattern_select,
  output logic smart_link_gas_alarm_enable,
  output logic drift_comp_enable,
  output logic hush_without_high_alarm,
  output logic hush_alarm_only,
  output logic smart_hush_cancel,
  output logic hush_enable,
  output logic battery_warning_hush_enable,
  output logic [2:0] battery_trip_point,
  output logic [1:0] emitter_current_select,
  output logic [1:0] integration_time_select,
  output logic [1:0] photo_gain_select,
  output logic [5:0] normal_alarm_limit,
  output logic [5:0] hysteresis_limit,
  output logic [5:0] hush_limit,
  output logic [5:0] chamber_check_limit,
  output logic [5:0] alarm_max_limit,
  output logic [5:0] drift_baseline,
  output logic [11:0] battery_trip_mv,
  output logic [11:0] emitter_current_ma,
  output logic [11:0] integration_time_us,
  output logic [2:0] photo_gain_factor
);

  // Linear decode of a small option code into its physical value
  // Shared by the four option tables, which differ only in base and step
  function automatic logic [11:0] scl_step_val(
    input logic [2:0] code,
    input logic [11:0] base,
    input logic [11:0] step
  );
    logic [11:0] prod;
    prod = 12'(step * {9'h000, code});
    return 12'(base + prod);
  endfunction : scl_step_val

  // Saturating width counter for qualifying pin pulses
  // Twenty bits cover the default store count with room to spare; a pin
  // stuck high saturates instead of wrapping round to a short count
  function automatic logic [19:0] scl_width_next(
    input logic level,
    input logic [19:0] cnt
  );
    if (!level) begin
      return 20'h00000;
    end
    if (cnt == WIDTH_SAT) begin
      return cnt;
    end
    return 20'(cnt + 20'h00001);
  endfunction : scl_width_next

  // State that lives on the shift clock
  // The toggle flips on every shift edge and is all the system side counts
  typedef struct packed {
    logic [57:0] shreg;
    logic tgl;
  } scl_link_s;

  // State that lives on the system clock. Every field resets to zero,
  // synchroniser stages included, which is the idle level of each pin,
  // so no false edge follows reset
  typedef struct packed {
    logic ent_s1;
    logic ent_s2;
    logic mclk_s1;
    logic mclk_s2;
    logic str_s1;
    logic str_s2;
    logic str_d;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_d;
    logic in_prog;
    logic [3:0] mode;
    logic setup_f;
    logic full_f;
    logic [19:0] mwid;
    logic mode_taken;
    logic [19:0] swid;
    logic [3:0] store_cnt;
    logic committed;
    logic [6:0] shift_cnt;
    logic [57:0] snap;
    logic [57:0] word;
    logic ee_wr;
    logic [57:0] ee_data;
    logic readout;
    logic [11:0] trip_mv;
    logic [11:0] emit_ma;
    logic [11:0] integ_us;
    logic [2:0] gain;
  } scl_sys_s;

  // Only the toggle and the quasi-static shift word cross from the link
  // side; nothing else there is read by the system side
  scl_link_s link_q;
  scl_link_s link_d;
  scl_sys_s sys_q;
  scl_sys_s sys_d;

  // Link side: the data pin is set up by the fixture around this very edge,
  // so it is sampled directly; a synchroniser would misalign the bits.
  always_comb begin
    link_d = link_q;
    link_d.shreg = {link_q.shreg[56:0], mode_data_pin};
    link_d.tgl = ~link_q.tgl;
  end

  // The link register runs only while the fixture clocks it; the shared
  // reset gives a fresh power-up an empty shift word
  always_ff @(posedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // System side: pin synchronisers, mode stepping, shift tracking, store
  // sequence, commit and readback
  always_comb begin
    logic shift_seen;
    logic store_fall;
    logic [6:0] rd_idx;
    shift_seen = 1'b0;
    store_fall = 1'b0;
    rd_idx = 7'h00;
    sys_d = sys_q;
    sys_d.ee_wr = 1'b0;

    // Two-flop synchronisers; the first stage feeds only the second.
    // The link activity crosses as a toggle, not a pulse, so a level
    // change is never lost whatever the phase of the two clocks.
    sys_d.ent_s1 = program_entry_pin;
    sys_d.ent_s2 = sys_q.ent_s1;
    sys_d.mclk_s1 = mode_boost_level;
    sys_d.mclk_s2 = sys_q.mclk_s1;
    sys_d.str_s1 = store_pin;
    sys_d.str_s2 = sys_q.str_s1;
    sys_d.str_d = sys_q.str_s2;
    sys_d.tgl_s1 = link_q.tgl;
    sys_d.tgl_s2 = sys_q.tgl_s1;
    sys_d.tgl_d = sys_q.tgl_s2;

    shift_seen = sys_q.tgl_s2 ^ sys_q.tgl_d;
    store_fall = sys_q.str_d & ~sys_q.str_s2;
    sys_d.in_prog = sys_q.ent_s2;

    // Pulse widths; a glitch shorter than the minimum never counts
    sys_d.mwid = scl_width_next(sys_q.mclk_s2, sys_q.mwid);
    sys_d.swid = scl_width_next(sys_q.str_s2, sys_q.swid);

    if (!sys_q.in_prog) begin
      // Entry low: all progress is forgotten, so a new pass needs every bit
      // The stored word and the snapshot survive, so readback after a
      // re-entry still shows what was committed last
      sys_d.mode = MODE_IDLE;
      sys_d.mode_taken = 1'b0;
      sys_d.store_cnt = 4'h0;
      sys_d.committed = 1'b0;
      sys_d.shift_cnt = 7'h00;
    end else begin
      // A boosted-rail swing held long enough steps the mode once;
      // mode_taken keeps one long high from counting as several clocks,
      // and a pulse that is too short leaves mwid below the minimum.
      // The count saturates at fifteen so it cannot wrap into a load mode.
      if (!sys_q.mclk_s2) begin
        sys_d.mode_taken = 1'b0;
      end else if (!sys_q.mode_taken && (sys_q.mwid >= 20'(MODE_MIN_CYC))) begin
        sys_d.mode_taken = 1'b1;
        if (sys_q.mode != 4'hF) begin
          sys_d.mode = 4'(sys_q.mode + 4'h1);
        end
      end

      // Count shift pulses seen since entry; saturation keeps a long burst
      // from wrapping back into the readable range and replaying the word
      if (shift_seen && (sys_q.shift_cnt != 7'h7F)) begin
        sys_d.shift_cnt = 7'(sys_q.shift_cnt + 7'h01);
      end

      // Store pulses count only in a load mode and only once per entry.
      // Counting on the fall means the high time is already known, so a
      // pulse cut short by entry dropping never counts. The tenth
      // qualified fall commits; later falls wait for a fresh entry.
      if (store_fall && !sys_q.committed && (sys_q.swid >= 20'(STORE_MIN_CYC)) &&
          ((sys_q.mode == MODE_SETUP) || (sys_q.mode == MODE_FULL))) begin
        sys_d.store_cnt = 4'(sys_q.store_cnt + 4'h1);
        if (sys_d.store_cnt == STORE_PULSES) begin
          sys_d.committed = 1'b1;
          sys_d.ee_wr = 1'b1;
          if (sys_q.mode == MODE_FULL) begin
            sys_d.word = sys_q.snap;
          end else begin
            // Last setup bit lands at the lowest shift stage
            sys_d.word[CFG_W-1:SETUP_LO] = sys_q.snap[SETUP_W-1:0];
          end
          sys_d.ee_data = sys_d.word;
        end
      end
    end

    // The shift word only moves on link edges; once the fixture stops
    // shifting it is static, so the last copy taken is coherent. Copies
    // taken mid-burst may be torn but are always overwritten.
    if (shift_seen) begin
      sys_d.snap = link_q.shreg;
    end

    // Readback walks the stored word from its top, one bit per shift pulse.
    // It is a mux over the stored word rather than a second shift register,
    // so reading never disturbs what will be committed; rd_idx wraps past
    // bit 57, and the guard below keeps those reads at zero.
    rd_idx = 7'(CFG_TOP - sys_q.shift_cnt);
    if ((sys_q.mode == MODE_FULL) && sys_q.in_prog) begin
      if (sys_q.shift_cnt <= CFG_TOP) begin
        sys_d.readout = sys_q.word[rd_idx[5:0]];
      end else begin
        sys_d.readout = 1'b0;
      end
    end else begin
      sys_d.readout = 1'b0;
    end

    // Mode flags are registered so the outputs come straight from
    // flip-flops; they trail the mode count by one cycle, in step with the
    // readout bit, which is decoded from the same registered state
    sys_d.setup_f = sys_q.in_prog && (sys_q.mode == MODE_SETUP);
    sys_d.full_f = sys_q.in_prog && (sys_q.mode == MODE_FULL);

    // Decoded physical values, registered to keep outputs on flip-flops
    // The tables are linear in the code, so one multiply-add serves all
    // four; a three-bit code times the step stays well inside twelve bits
    sys_d.trip_mv = scl_step_val(sys_q.word[LO_BAT_TRIP +: 3], TRIP_BASE_MV,
                                 TRIP_STEP_MV);
    sys_d.emit_ma = scl_step_val({1'b0, sys_q.word[LO_EMITTER +: 2]}, EMIT_BASE_MA,
                                 EMIT_STEP_MA);
    sys_d.integ_us = scl_step_val({1'b0, sys_q.word[LO_INTEG +: 2]}, INTEG_BASE_US,
                                  INTEG_STEP_US);
    sys_d.gain = 3'(scl_step_val({1'b0, sys_q.word[LO_GAIN +: 2]}, GAIN_BASE,
                                 GAIN_STEP));
  end

  // Reset clears the stored word as well: there is no power-on value for
  // the settings, so every field starts at zero until a commit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sys_q <= '0;
    end else begin
      sys_q <= sys_d;
    end
  end

  // Status and commit interface. The commit strobe and its data stand
  // together for one cycle; the data word then holds until the next commit
  assign serial_readout_pin = sys_q.readout;
  assign prog_active = sys_q.in_prog;
  assign setup_load_mode = sys_q.setup_f;
  assign full_load_mode = sys_q.full_f;
  assign mode_count = sys_q.mode;
  assign store_count = sys_q.store_cnt;
  assign store_done = sys_q.committed;
  assign bits_shifted = sys_q.shift_cnt;
  assign eeprom_write = sys_q.ee_wr;
  assign eeprom_data = sys_q.ee_data;
  assign config_word = sys_q.word;

  // Feature flags straight from the stored word; fields change only at a
  // commit, so downstream logic sees one consistent set of options
  assign factory_bit = sys_q.word[BIT_FACTORY];
  assign boost_level_select = sys_q.word[BIT_BOOST];
  assign alarm_memory_enable = sys_q.word[BIT_ALARM_MEM];
  assign auto_locate_enable = sys_q.word[BIT_AUTO_LOC];
  assign horn_sync_enable = sys_q.word[BIT_HORN_SYNC];
  assign horn_pattern_select = sys_q.word[BIT_HORN_PAT];
  assign smart_link_gas_alarm_enable = sys_q.word[BIT_GAS_LINK];
  assign drift_comp_enable = sys_q.word[BIT_DRIFT_EN];
  assign hush_without_high_alarm = sys_q.word[BIT_HUSH_NO_HI];
  assign hush_alarm_only = sys_q.word[BIT_HUSH_ALM];
  assign smart_hush_cancel = sys_q.word[BIT_HUSH_CANCEL];
  assign hush_enable = sys_q.word[BIT_HUSH_EN];
  assign battery_warning_hush_enable = sys_q.word[BIT_BAT_HUSH];

  // Option codes and limits
  // Limits are plain six-bit unsigned values with no decoding
  assign battery_trip_point = sys_q.word[LO_BAT_TRIP +: 3];
  assign emitter_current_select = sys_q.word[LO_EMITTER +: 2];
  assign integration_time_select = sys_q.word[LO_INTEG +: 2];
  assign photo_gain_select = sys_q.word[LO_GAIN +: 2];
  assign normal_alarm_limit = sys_q.word[LO_NORMAL +: 6];
  assign hysteresis_limit = sys_q.word[LO_HYST +: 6];
  assign hush_limit = sys_q.word[LO_HUSH +: 6];
  assign chamber_check_limit = sys_q.word[LO_CHAMBER +: 6];
  assign alarm_max_limit = sys_q.word[LO_ALARM_MAX +: 6];
  assign drift_baseline = sys_q.word[LO_BASELINE +: 6];

  // Decoded values
  assign battery_trip_mv = sys_q.trip_mv;
  assign emitter_current_ma = sys_q.emit_ma;
  assign integration_time_us = sys_q.integ_us;
  assign photo_gain_factor = sys_q.gain;

endmodule : scl_loader

// file: verilog/scl_pkg.sv
/*
  Shared constants for the serial configuration loader: word layout, field
  positions, load modes, store sequence and timing.
  Assumes a 50 MHz system clock; the long timing counts become top-level
  parameters of the loader, with the defaults below.
*/
package scl_pkg;

  // Configuration and calibration word
  localparam int CFG_W = 58;
  localparam logic [6:0] CFG_TOP = 7'h39;
  localparam logic [57:0] CFG_RESET = 58'h0;
  localparam int SETUP_W = 22;
  localparam int SETUP_LO = 36;

  // Load modes, as a count of mode clocks after programming entry
  localparam logic [3:0] MODE_IDLE = 4'h0;
  localparam logic [3:0] MODE_SETUP = 4'h2;
  localparam logic [3:0] MODE_FULL = 4'h8;

  // Store sequence
  localparam logic [3:0] STORE_PULSES = 4'hA;

  // Single-bit field positions
  localparam int BIT_FACTORY = 57;
  localparam int BIT_BOOST = 56;
  localparam int BIT_ALARM_MEM = 55;
  localparam int BIT_AUTO_LOC = 54;
  localparam int BIT_HORN_SYNC = 53;
  localparam int BIT_HORN_PAT = 52;
  localparam int BIT_GAS_LINK = 51;
  localparam int BIT_DRIFT_EN = 50;
  localparam int BIT_HUSH_NO_HI = 49;
  localparam int BIT_HUSH_ALM = 48;
  localparam int BIT_HUSH_CANCEL = 47;
  localparam int BIT_HUSH_EN = 46;
  localparam int BIT_BAT_HUSH = 45;

  // Multi-bit field low positions
  localparam int LO_BAT_TRIP = 42;
  localparam int LO_EMITTER = 40;
  localparam int LO_INTEG = 38;
  localparam int LO_GAIN = 36;
  localparam int LO_NORMAL = 30;
  localparam int LO_HYST = 24;
  localparam int LO_HUSH = 18;
  localparam int LO_CHAMBER = 12;
  localparam int LO_ALARM_MAX = 6;
  localparam int LO_BASELINE = 0;

  // Decoded value tables: base and step per code
  localparam logic [11:0] TRIP_BASE_MV = 12'h834;
  localparam logic [11:0] TRIP_STEP_MV = 12'h064;
  localparam logic [11:0] EMIT_BASE_MA = 12'h032;
  localparam logic [11:0] EMIT_STEP_MA = 12'h032;
  localparam logic [11:0] INTEG_BASE_US = 12'h064;
  localparam logic [11:0] INTEG_STEP_US = 12'h064;
  localparam logic [11:0] GAIN_BASE = 12'h001;
  localparam logic [11:0] GAIN_STEP = 12'h001;

  // Timing
  localparam int SYS_CLK_MHZ = 50;
  localparam int MODE_MIN_US = 100;
  localparam int STORE_HIGH_US = 5000;
  localparam int MODE_MIN_CYC_DEF = MODE_MIN_US * SYS_CLK_MHZ;
  localparam int STORE_MIN_CYC_DEF = (STORE_HIGH_US * SYS_CLK_MHZ) / 2;
  localparam logic [19:0] WIDTH_SAT = 20'hFFFFF;

endpackage : scl_pkg
